// ---- logic/pipf_filter.sv ----
// request qualifier: line must stay true for a full hold time
`timescale 1ns/1ps
module pipf_filter
    import pipf_pkg::*;
#(
    parameter int HOLD = REQ_HOLD_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic line,
    output logic qualified
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_qualified;

    always_comb
    begin
        next_count = count;
        next_qualified = 1'b0;
        if (!line)
        begin
            next_count = '0;
        end
        else if (count >= CNT_W'(HOLD - 1))
        begin
            next_qualified = 1'b1;
        end
        else
        begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            count <= '0;
            qualified <= 1'b0;
        end
        else
        begin
            count <= next_count;
            qualified <= next_qualified;
        end
    end

    property p_hold;
        @(posedge clk) disable iff (!resetn)
        $rose(qualified) |-> $past(line, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("qualified without held line");
endmodule

// ---- logic/pipf_pkg.sv ----
// shared constants for the priority interrupt and power-fail block
package pipf_pkg;
    localparam int CLK_MHZ = 100;
    localparam int REQ_HOLD_US = 8;
    localparam int REQ_HOLD_CYC = REQ_HOLD_US * CLK_MHZ;
    localparam int SINGLE_REL_US = 16;
    localparam int SINGLE_REL_CYC = SINGLE_REL_US * CLK_MHZ;
    localparam int NCHAN = 16;
    localparam int ADDR_W = 14;
    localparam logic [13:0] ADDR_SHUTDOWN = 14'h001F;
    localparam logic [13:0] ADDR_RESTART = 14'h001E;
    localparam logic [13:0] ADDR_CHAN_BASE = 14'h0020;
    localparam int CNT_W = 11;
    typedef enum logic [2:0] {
        PIPF_RUN,
        PIPF_SAVE,
        PIPF_DOWN,
        PIPF_START,
        PIPF_RESTART
    } pipf_pwr_t;
endpackage

// ---- logic/pipf_top.sv ----
// priority interrupt logic with power-fail shutdown and restart
// ----------------------------------------------------------------
// Notes on behaviour
// - A recognised request is served at the end of the current instruction by a jump to its address.
// - No channel is taken while a higher-priority request is pending.
// - Each channel can be set to single-execution mode by its own setting.
// - Delay to the vector varies with instruction time and higher-priority service.
// - On power failure all register state is saved to core.
// - After the save, core writes stay blocked while the supply decays.
// - Power-fail uses two dedicated channels, shutdown and restart.
// - Power loss vectors to location 037.
// - On power return, start is pulsed before the restart interrupt.
// - After start, an interrupt vectors to location 036.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module pipf_top
    import pipf_pkg::*;
#(
    parameter int HOLD = REQ_HOLD_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [NCHAN-1:0] irq_line,
    input wire logic [NCHAN-1:0] single_mode,
    input wire logic instr_done,
    input wire logic routine_end,
    input wire logic [NCHAN-1:0] routine_chan,
    input wire logic power_ok,
    input wire logic save_done,
    input wire logic start_done,
    output logic vec_valid,
    output logic [ADDR_W-1:0] vec_addr,
    output logic [NCHAN-1:0] active,
    output logic save_req,
    output logic core_write_inhibit,
    output logic start_pulse
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [NCHAN-1:0] irq_s1;
    logic [NCHAN-1:0] irq_s2;
    logic pwr_s1;
    logic pwr_s2;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_s1 <= '0;
            irq_s2 <= '0;
            pwr_s1 <= 1'b1;
            pwr_s2 <= 1'b1;
        end
        else
        begin
            irq_s1 <= irq_line;
            irq_s2 <= irq_s1;
            pwr_s1 <= power_ok;
            pwr_s2 <= pwr_s1;
        end
    end

    // ----------------------------------------------------------------
    // qualifiers
    // ----------------------------------------------------------------
    logic [NCHAN-1:0] qual;

    genvar g;
    generate
        for (g = 0; g < NCHAN; g++)
        begin : g_flt
            pipf_filter #(.HOLD(HOLD)) u_flt (
                .clk(clk),
                .resetn(resetn),
                .line(irq_s2[g]),
                .qualified(qual[g])
            );
        end
    endgenerate

    function automatic logic [ADDR_W-1:0] chan_addr(input logic [3:0] idx);
        chan_addr = ADDR_CHAN_BASE + ADDR_W'(idx);
    endfunction

    // ----------------------------------------------------------------
    // pending, arbitration, power sequencing
    // ----------------------------------------------------------------
    logic [NCHAN-1:0] pend;
    logic [NCHAN-1:0] armed;
    logic pf_pend;
    logic rs_pend;
    pipf_pwr_t pstate;
    logic [NCHAN-1:0] next_pend;
    logic [NCHAN-1:0] next_armed;
    logic [NCHAN-1:0] next_active;
    logic next_pf_pend;
    logic next_rs_pend;
    pipf_pwr_t next_pstate;
    logic next_vec_valid;
    logic [ADDR_W-1:0] next_vec_addr;
    logic next_save_req;
    logic next_inhibit;
    logic next_start;
    logic taken;
    logic [NCHAN-1:0] fire;

    always_comb
    begin
        next_pend = pend;
        next_armed = armed;
        next_active = active;
        next_pf_pend = pf_pend;
        next_rs_pend = rs_pend;
        next_pstate = pstate;
        next_vec_valid = 1'b0;
        next_vec_addr = vec_addr;
        next_save_req = 1'b0;
        next_inhibit = core_write_inhibit;
        next_start = 1'b0;
        taken = 1'b0;
        // a channel fires once per assertion; single mode rearms on line drop,
        // standard mode also waits for its routine to end
        for (int i = 0; i < NCHAN; i++)
        begin
            fire[i] = qual[i] && armed[i];
            if (routine_end && routine_chan[i])
            begin
                next_active[i] = 1'b0;
            end
            if (!irq_s2[i] && (single_mode[i] || !active[i]))
            begin
                next_armed[i] = 1'b1;
            end
            if (fire[i])
            begin
                next_armed[i] = 1'b0;
                next_pend[i] = 1'b1;
            end
        end
        unique case (pstate)
            PIPF_RUN:
            begin
                if (!pwr_s2)
                begin
                    next_pstate = PIPF_SAVE;
                    next_pf_pend = 1'b1;
                end
            end
            PIPF_SAVE:
            begin
                next_save_req = 1'b1;
                if (save_done)
                begin
                    next_save_req = 1'b0;
                    next_pstate = PIPF_DOWN;
                    next_inhibit = 1'b1;
                end
            end
            PIPF_DOWN:
            begin
                if (pwr_s2)
                begin
                    next_pstate = PIPF_START;
                    next_inhibit = 1'b0;
                    next_start = 1'b1;
                end
            end
            PIPF_START:
            begin
                if (start_done)
                begin
                    next_pstate = PIPF_RESTART;
                    next_rs_pend = 1'b1;
                end
            end
            PIPF_RESTART:
            begin
                if (!rs_pend)
                begin
                    next_pstate = PIPF_RUN;
                end
            end
        endcase
        if (instr_done && pstate != PIPF_DOWN && pstate != PIPF_START)
        begin
            if (pf_pend)
            begin
                next_pf_pend = 1'b0;
                next_vec_valid = 1'b1;
                next_vec_addr = ADDR_SHUTDOWN;
                taken = 1'b1;
            end
            else if (rs_pend)
            begin
                next_rs_pend = 1'b0;
                next_vec_valid = 1'b1;
                next_vec_addr = ADDR_RESTART;
                taken = 1'b1;
            end
            // lowest index wins, blocked by active higher
            else
            begin
                for (int i = NCHAN - 1; i >= 0; i--)
                begin
                    if (pend[i] && ((active & ((16'h0001 << i) - 16'h0001)) == 16'h0000)
                        && !active[i])
                    begin
                        next_vec_addr = chan_addr(4'(i));
                        taken = 1'b1;
                    end
                end
                if (taken)
                begin
                    next_vec_valid = 1'b1;
                    for (int i = 0; i < NCHAN; i++)
                    begin
                        if (next_vec_addr == chan_addr(4'(i)))
                        begin
                            // new request in same cycle stays pending
                            next_pend[i] = fire[i];
                            next_active[i] = !single_mode[i];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pend <= '0;
            armed <= '1;
            active <= '0;
            pf_pend <= 1'b0;
            rs_pend <= 1'b0;
            pstate <= PIPF_RUN;
            vec_valid <= 1'b0;
            vec_addr <= '0;
            save_req <= 1'b0;
            core_write_inhibit <= 1'b0;
            start_pulse <= 1'b0;
        end
        else
        begin
            pend <= next_pend;
            armed <= next_armed;
            active <= next_active;
            pf_pend <= next_pf_pend;
            rs_pend <= next_rs_pend;
            pstate <= next_pstate;
            vec_valid <= next_vec_valid;
            vec_addr <= next_vec_addr;
            save_req <= next_save_req;
            core_write_inhibit <= next_inhibit;
            start_pulse <= next_start;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_vec_at_end;
        @(posedge clk) disable iff (!resetn)
        vec_valid |-> $past(instr_done);
    endproperty
    a_vec_at_end: assert property (p_vec_at_end) else $error("vector not at instr end");

    property p_prio;
        @(posedge clk) disable iff (!resetn)
        (vec_valid && vec_addr == ADDR_CHAN_BASE + 14'h0001) |-> !$past(pend[0]);
    endproperty
    a_prio: assert property (p_prio) else $error("channel 1 taken over channel 0");

    property p_no_higher;
        @(posedge clk) disable iff (!resetn)
        (vec_valid && vec_addr == ADDR_CHAN_BASE + 14'h0001) |-> !$past(active[0]);
    endproperty
    a_no_higher: assert property (p_no_higher) else $error("taken under higher active");

    property p_shut;
        @(posedge clk) disable iff (!resetn)
        (pf_pend && instr_done && pstate == PIPF_SAVE) |=> vec_valid && vec_addr == ADDR_SHUTDOWN;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown vector");

    property p_inh;
        @(posedge clk) disable iff (!resetn)
        (pstate == PIPF_DOWN) |-> core_write_inhibit;
    endproperty
    a_inh: assert property (p_inh) else $error("core writes not inhibited");

    property p_save;
        @(posedge clk) disable iff (!resetn)
        $fell(pwr_s2) && pstate == PIPF_RUN |=> ##1 save_req;
    endproperty
    a_save: assert property (p_save) else $error("no save on power loss");

    property p_start;
        @(posedge clk) disable iff (!resetn)
        (pstate == PIPF_DOWN && pwr_s2) |=> start_pulse && !rs_pend;
    endproperty
    a_start: assert property (p_start) else $error("start not before restart");

    property p_restart;
        @(posedge clk) disable iff (!resetn)
        (rs_pend && !pf_pend && instr_done) |=> vec_valid && vec_addr == ADDR_RESTART;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart vector");

    property p_single;
        @(posedge clk) disable iff (!resetn)
        (vec_valid && vec_addr == ADDR_CHAN_BASE && $past(single_mode[0])) |-> !active[0];
    endproperty
    a_single: assert property (p_single) else $error("single channel left active");
endmodule

// ---- testbench/pipf_requester.sv ----
// request line model for the external equipment side
`timescale 1ns/1ps
module pipf_requester
    import pipf_pkg::*;
#(
    parameter int HOLDC = 12
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [NCHAN-1:0] raise,
    input wire logic short_req,
    output logic [NCHAN-1:0] irq_line
);
    logic [7:0] cnt;

    // --------------------------------
    // line driver
    // --------------------------------
    // hold, then release
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_line <= '0;
            cnt <= '0;
        end
        else if (raise != '0)
        begin
            irq_line <= raise;
            cnt <= short_req ? 8'h02 : 8'(HOLDC);
        end
        else if (cnt != '0)
            cnt <= cnt - 8'h01;
        else
            irq_line <= '0;
    end
endmodule

// ---- testbench/test_priority_interrupt_powerfail.sv ----
// self-checking bench for the priority interrupt and power-fail block
`timescale 1ns/1ps
module test_priority_interrupt_powerfail
    import pipf_pkg::*;
;
    logic clk, resetn, instr_done, routine_end, power_ok, save_done, start_done, short_req;
    logic [NCHAN-1:0] irq_line, single_mode, routine_chan, raise, active;
    logic vec_valid, save_req, core_write_inhibit, start_pulse;
    logic [ADDR_W-1:0] vec_addr;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    pipf_top #(.HOLD(4)) dut_u (.clk(clk), .resetn(resetn), .irq_line(irq_line),
        .single_mode(single_mode), .instr_done(instr_done), .routine_end(routine_end),
        .routine_chan(routine_chan), .power_ok(power_ok), .save_done(save_done),
        .start_done(start_done), .vec_valid(vec_valid), .vec_addr(vec_addr),
        .active(active), .save_req(save_req), .core_write_inhibit(core_write_inhibit),
        .start_pulse(start_pulse));

    pipf_requester #(.HOLDC(12)) req_u (.clk(clk), .resetn(resetn), .raise(raise),
        .short_req(short_req), .irq_line(irq_line));

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic rq(input logic [15:0] m, input logic s);
        @(posedge clk) raise <= m;
        short_req <= s;
        @(posedge clk) raise <= '0;
        repeat (16) @(posedge clk);
    endtask

    task automatic instr(input logic v, input logic [13:0] a);
        @(posedge clk) instr_done <= 1'b1;
        @(posedge clk) instr_done <= 1'b0;
        #1;
        chk({15'h0000, vec_valid}, {15'h0000, v});
        if (v)
            chk({2'h0, vec_addr}, {2'h0, a});
    endtask

    task automatic fin(input logic [15:0] m);
        @(posedge clk) routine_end <= 1'b1;
        routine_chan <= m;
        @(posedge clk) routine_end <= 1'b0;
        routine_chan <= '0;
        #1;
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_standard;
        rq(16'h0008, 1'b0);
        instr(1'b1, 14'h0023);
        chk(active, 16'h0008);
        fin(16'h0008);
        chk(active, 16'h0000);
    endtask

    task automatic t_priority;
        rq(16'h0024, 1'b0);
        instr(1'b1, 14'h0022);
        instr(1'b0, 14'h0000);
        fin(16'h0004);
        instr(1'b1, 14'h0025);
        fin(16'h0020);
    endtask

    task automatic t_pair;
        rq(16'h0003, 1'b0);
        instr(1'b1, 14'h0020);
        instr(1'b0, 14'h0000);
        fin(16'h0001);
        instr(1'b1, 14'h0021);
        fin(16'h0002);
    endtask

    task automatic t_single;
        @(posedge clk) single_mode <= 16'h0001;
        rq(16'h0001, 1'b0);
        instr(1'b1, 14'h0020);
        chk(active, 16'h0000);
        @(posedge clk) single_mode <= '0;
    endtask

    task automatic t_short;
        rq(16'h0002, 1'b1);
        instr(1'b0, 14'h0000);
    endtask

    task automatic t_power;
        int i;
        @(posedge clk) power_ok <= 1'b0;
        for (i = 0; i < 10 && save_req !== 1'b1; i++)
            @(posedge clk) #1;
        chk({15'h0000, save_req}, 16'h0001);
        instr(1'b1, 14'h001F);
        @(posedge clk) save_done <= 1'b1;
        @(posedge clk) save_done <= 1'b0;
        @(posedge clk) #1;
        chk({15'h0000, core_write_inhibit}, 16'h0001);
        instr(1'b0, 14'h0000);
        repeat (20) @(posedge clk);
        #1;
        chk({15'h0000, core_write_inhibit}, 16'h0001);
        @(posedge clk) power_ok <= 1'b1;
        for (i = 0; i < 10 && start_pulse !== 1'b1; i++)
            @(posedge clk) #1;
        chk({15'h0000, start_pulse}, 16'h0001);
        chk({15'h0000, core_write_inhibit}, 16'h0000);
        @(posedge clk) start_done <= 1'b1;
        @(posedge clk) start_done <= 1'b0;
        // restart interrupt after start vectors to 036
        instr(1'b1, 14'h001E);
    endtask

    // --------------------------------
    // clock, timeout, main sequence
    // --------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        resetn = 1'b0;
        instr_done = 1'b0;
        routine_end = 1'b0;
        routine_chan = '0;
        single_mode = '0;
        power_ok = 1'b1;
        save_done = 1'b0;
        start_done = 1'b0;
        raise = '0;
        short_req = 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk) #1;
        chk({12'h000, vec_valid, save_req, core_write_inhibit, start_pulse}, 16'h0000);
        chk(active, 16'h0000);
        t_standard();
        t_priority();
        t_pair();
        t_single();
        t_short();
        t_power();
        conclude();
    end
endmodule
